//--- logic/vobei_incrementer.sv
// Purpose: per-instruction increments for element and byte events
// Assumes: one instruction per cycle, fields valid with instr.valid
// Notes:   increments registered one cycle after the instruction
//
// How it works
// - scalable fp64 adds 2, fused 4
// - only scalable fp64 ops feed that event
// - fixed fp64: vector 2, scalar 1, fused doubled
// - scalable int adds 128/container, fused doubled
// - fixed int: elements or 1, fused doubled
// - scalable ldst: 128/container times registers
// - fixed ldst: single 1, pair 2, atomics
// - replicate loads and multi-structure fixed ldst
// - scalable loads: 128/container times registers
// - fixed loads: single, pair, atomic, replicate, multi
// - scalable stores: 128/container times registers
// - fixed stores: single, pair, atomic, multi
// - scalable ldst bytes: 16/(container/memory) times regs
// - fixed ldst bytes: memory/8, doubled pair, atomic load
// - quadword replicate 16, multi bytes times regs
// - scalable load bytes likewise
// - fixed load bytes per access kind
// - scalable store bytes likewise
// - fixed store bytes per access kind
`timescale 1ns/100ps
`default_nettype none
`include "vobei_map.svh"

module vobei_incrementer
  import vobei_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire vobei_instr_t instr,
  output var  vobei_incs_t  incs
);

  ////////////////////////////////////////////////////////////////////////////
  // shared arithmetic

  // elements in a 128-bit granule; unknown sizes give zero
  function automatic vobei_inc_t per_granule(input logic [7:0] bits);
    unique case (bits)
      8'h08:   per_granule = 8'h10;
      8'h10:   per_granule = 8'h08;
      8'h20:   per_granule = 8'h04;
      8'h40:   per_granule = 8'h02;
      8'h80:   per_granule = 8'h01;
      default: per_granule = 8'h00;
    endcase
  endfunction

  function automatic vobei_inc_t bytes_of(input logic [7:0] bits);
    bytes_of = {3'h0, bits[7:3]};
  endfunction

  function automatic vobei_inc_t times_regs(input vobei_inc_t v,
                                             input logic [2:0] r);
    logic [10:0] p;
    p = 11'(v) * 11'(r);
    times_regs = p[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  vobei_incs_t  nxt_incs;
  vobei_inc_t   gran_c;
  vobei_inc_t   gran_m;
  vobei_inc_t   bytes_m;
  vobei_inc_t   sc_bytes;
  vobei_inc_t   one_elem;
  logic         is_ld;
  logic         is_st;

  always_comb
  begin
    gran_c   = per_granule(instr.container_bits);
    gran_m   = per_granule(instr.memory_element_bits);
    bytes_m  = bytes_of(instr.memory_element_bits);
    // 16/(c/m) = 16*m/c = bytes per 128-bit register given container
    sc_bytes = 8'(gran_c * bytes_m);
    one_elem = instr.vector ? gran_c : `VOBEI_ONE;
    nxt_incs = '0;
    is_ld    = 1'b0;
    is_st    = 1'b0;
    if (instr.valid)
    begin
      unique case (instr.iclass)
        VOBEI_CL_FP64:
        begin
          if (instr.scalable)
            nxt_incs.fp64_scalable_ops_event = instr.fused ?
              8'(`VOBEI_FP64_SC_INC << 1) : `VOBEI_FP64_SC_INC;
          else
            nxt_incs.fp64_fixed_ops_event =
              (instr.vector ? `VOBEI_FP64_FX_VEC : `VOBEI_ONE)
              << instr.fused;
        end
        VOBEI_CL_INT:
        begin
          if (instr.scalable)
            nxt_incs.int_scalable_ops_event = 8'(gran_c << instr.fused);
          else
            nxt_incs.int_fixed_ops_event = 8'(one_elem << instr.fused);
        end
        VOBEI_CL_LOAD, VOBEI_CL_STORE:
        begin
          is_ld = (instr.iclass == VOBEI_CL_LOAD);
          is_st = !is_ld;
          if (instr.scalable)
          begin
            nxt_incs.ldst_scalable_ops_event =
              times_regs(gran_c, instr.regs);
            nxt_incs.ldst_scalable_bytes_event =
              times_regs(sc_bytes, instr.regs);
          end
          else
          begin
            nxt_incs.ldst_fixed_ops_event = `VOBEI_ONE;
            nxt_incs.ldst_fixed_bytes_event = bytes_m;
          end
        end
        VOBEI_CL_PAIR_LD, VOBEI_CL_PAIR_ST:
        begin
          is_ld = (instr.iclass == VOBEI_CL_PAIR_LD);
          is_st = !is_ld;
          nxt_incs.ldst_fixed_ops_event = `VOBEI_TWO;
          nxt_incs.ldst_fixed_bytes_event = 8'(bytes_m << 1);
        end
        VOBEI_CL_ATOM_LD:
        begin
          nxt_incs.ldst_fixed_ops_event = `VOBEI_TWO;
          nxt_incs.ldst_fixed_bytes_event = 8'(bytes_m << 1);
          nxt_incs.ld_fixed_ops_event = `VOBEI_ONE;
          nxt_incs.ld_fixed_bytes_event = bytes_m;
          nxt_incs.st_fixed_bytes_event = bytes_m;
        end
        VOBEI_CL_ATOM_ST:
        begin
          nxt_incs.ldst_fixed_ops_event = `VOBEI_ONE;
          nxt_incs.ldst_fixed_bytes_event = bytes_m;
          nxt_incs.st_fixed_ops_event = `VOBEI_ONE;
        end
        VOBEI_CL_REPL1:
        begin
          nxt_incs.ldst_fixed_ops_event = `VOBEI_ONE;
          nxt_incs.ld_fixed_ops_event = `VOBEI_ONE;
          nxt_incs.ldst_fixed_bytes_event = bytes_m;
          nxt_incs.ld_fixed_bytes_event = bytes_m;
        end
        VOBEI_CL_REPLQ:
        begin
          nxt_incs.ldst_fixed_ops_event = gran_c;
          nxt_incs.ld_fixed_ops_event = gran_c;
          nxt_incs.ldst_fixed_bytes_event = `VOBEI_GRANULE_BYTES;
          nxt_incs.ld_fixed_bytes_event = `VOBEI_GRANULE_BYTES;
        end
        VOBEI_CL_MULTI_LD, VOBEI_CL_MULTI_ST:
        begin
          is_ld = (instr.iclass == VOBEI_CL_MULTI_LD);
          is_st = !is_ld;
          // elements per vector counted from the memory element size
          nxt_incs.ldst_fixed_ops_event =
            times_regs(gran_m, instr.regs);
          nxt_incs.ldst_fixed_bytes_event =
            times_regs(`VOBEI_GRANULE_BYTES, instr.regs);
        end
        default:
        begin
          nxt_incs = '0;
        end
      endcase
      // load and store splits mirror the combined figures
      if (is_ld)
      begin
        nxt_incs.ld_scalable_ops_event =
          nxt_incs.ldst_scalable_ops_event;
        nxt_incs.ld_scalable_bytes_event =
          nxt_incs.ldst_scalable_bytes_event;
        nxt_incs.ld_fixed_ops_event = nxt_incs.ldst_fixed_ops_event;
        nxt_incs.ld_fixed_bytes_event =
          nxt_incs.ldst_fixed_bytes_event;
      end
      if (is_st)
      begin
        nxt_incs.st_scalable_ops_event =
          nxt_incs.ldst_scalable_ops_event;
        nxt_incs.st_scalable_bytes_event =
          nxt_incs.ldst_scalable_bytes_event;
        nxt_incs.st_fixed_ops_event = nxt_incs.ldst_fixed_ops_event;
        nxt_incs.st_fixed_bytes_event =
          nxt_incs.ldst_fixed_bytes_event;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered increments; counters take them the next cycle
  // one register per event so each output is a plain flop

  vobei_inc_t fp64_sc_ops_ff;
  vobei_inc_t fp64_fx_ops_ff;
  vobei_inc_t int_sc_ops_ff;
  vobei_inc_t int_fx_ops_ff;
  vobei_inc_t ldst_sc_ops_ff;
  vobei_inc_t ldst_fx_ops_ff;
  vobei_inc_t ld_sc_ops_ff;
  vobei_inc_t ld_fx_ops_ff;
  vobei_inc_t st_sc_ops_ff;
  vobei_inc_t st_fx_ops_ff;
  vobei_inc_t ldst_sc_bytes_ff;
  vobei_inc_t ldst_fx_bytes_ff;
  vobei_inc_t ld_sc_bytes_ff;
  vobei_inc_t ld_fx_bytes_ff;
  vobei_inc_t st_sc_bytes_ff;
  vobei_inc_t st_fx_bytes_ff;

  // floating-point element operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fp64_sc_ops_ff <= '0;
      fp64_fx_ops_ff <= '0;
    end
    else
    begin
      fp64_sc_ops_ff <= nxt_incs.fp64_scalable_ops_event;
      fp64_fx_ops_ff <= nxt_incs.fp64_fixed_ops_event;
    end
  end

  // integer element operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      int_sc_ops_ff <= '0;
      int_fx_ops_ff <= '0;
    end
    else
    begin
      int_sc_ops_ff <= nxt_incs.int_scalable_ops_event;
      int_fx_ops_ff <= nxt_incs.int_fixed_ops_event;
    end
  end

  // combined load and store element operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ldst_sc_ops_ff <= '0;
      ldst_fx_ops_ff <= '0;
    end
    else
    begin
      ldst_sc_ops_ff <= nxt_incs.ldst_scalable_ops_event;
      ldst_fx_ops_ff <= nxt_incs.ldst_fixed_ops_event;
    end
  end

  // load element operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ld_sc_ops_ff <= '0;
      ld_fx_ops_ff <= '0;
    end
    else
    begin
      ld_sc_ops_ff <= nxt_incs.ld_scalable_ops_event;
      ld_fx_ops_ff <= nxt_incs.ld_fixed_ops_event;
    end
  end

  // store element operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_sc_ops_ff <= '0;
      st_fx_ops_ff <= '0;
    end
    else
    begin
      st_sc_ops_ff <= nxt_incs.st_scalable_ops_event;
      st_fx_ops_ff <= nxt_incs.st_fixed_ops_event;
    end
  end

  // combined load and store bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ldst_sc_bytes_ff <= '0;
      ldst_fx_bytes_ff <= '0;
    end
    else
    begin
      ldst_sc_bytes_ff <= nxt_incs.ldst_scalable_bytes_event;
      ldst_fx_bytes_ff <= nxt_incs.ldst_fixed_bytes_event;
    end
  end

  // load bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ld_sc_bytes_ff <= '0;
      ld_fx_bytes_ff <= '0;
    end
    else
    begin
      ld_sc_bytes_ff <= nxt_incs.ld_scalable_bytes_event;
      ld_fx_bytes_ff <= nxt_incs.ld_fixed_bytes_event;
    end
  end

  // store bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_sc_bytes_ff <= '0;
      st_fx_bytes_ff <= '0;
    end
    else
    begin
      st_sc_bytes_ff <= nxt_incs.st_scalable_bytes_event;
      st_fx_bytes_ff <= nxt_incs.st_fixed_bytes_event;
    end
  end

  assign incs = '{
    fp64_scalable_ops_event:   fp64_sc_ops_ff,
    fp64_fixed_ops_event:      fp64_fx_ops_ff,
    int_scalable_ops_event:    int_sc_ops_ff,
    int_fixed_ops_event:       int_fx_ops_ff,
    ldst_scalable_ops_event:   ldst_sc_ops_ff,
    ldst_fixed_ops_event:      ldst_fx_ops_ff,
    ld_scalable_ops_event:     ld_sc_ops_ff,
    ld_fixed_ops_event:        ld_fx_ops_ff,
    st_scalable_ops_event:     st_sc_ops_ff,
    st_fixed_ops_event:        st_fx_ops_ff,
    ldst_scalable_bytes_event: ldst_sc_bytes_ff,
    ldst_fixed_bytes_event:    ldst_fx_bytes_ff,
    ld_scalable_bytes_event:   ld_sc_bytes_ff,
    ld_fixed_bytes_event:      ld_fx_bytes_ff,
    st_scalable_bytes_event:   st_sc_bytes_ff,
    st_fixed_bytes_event:      st_fx_bytes_ff
  };

endmodule

`default_nettype wire

//--- logic/vobei_map.svh
// Purpose: offsets, field constants and counts for the event incrementer
// Assumes: included by the package and the design file
// Notes:   definitions only
`ifndef VOBEI_MAP_SVH
`define VOBEI_MAP_SVH
`define VOBEI_EV_FP64_SC    16'h80C6
`define VOBEI_EV_FP64_FX    16'h80C7
`define VOBEI_EV_INT_SC     16'h80C8
`define VOBEI_EV_INT_FX     16'h80C9
`define VOBEI_EV_LDST_SC    16'h80CA
`define VOBEI_EV_LDST_FX    16'h80CB
`define VOBEI_EV_LD_SC      16'h80CC
`define VOBEI_EV_LD_FX      16'h80CD
`define VOBEI_EV_ST_SC      16'h80CE
`define VOBEI_EV_ST_FX      16'h80CF
`define VOBEI_EV_LDSTB_SC   16'h80DA
`define VOBEI_EV_LDSTB_FX   16'h80DB
`define VOBEI_EV_LDB_SC     16'h80DC
`define VOBEI_EV_LDB_FX     16'h80DD
`define VOBEI_EV_STB_SC     16'h80DE
`define VOBEI_EV_STB_FX     16'h80DF
`define VOBEI_GRANULE_BITS  9'h080
`define VOBEI_GRANULE_BYTES 8'h10
`define VOBEI_FP64_SC_INC   8'h02
`define VOBEI_FP64_FX_VEC   8'h02
`define VOBEI_ONE           8'h01
`define VOBEI_TWO           8'h02
`define VOBEI_NUM_EVENTS    16
`endif

//--- logic/vobei_pkg.sv
// Purpose: types shared by the event incrementer
// Assumes: vobei_map.svh holds the numeric constants
// Notes:   class codes are binary, written out
package vobei_pkg;
  `include "vobei_map.svh"

  typedef enum logic [3:0] {
    VOBEI_CL_NONE      = 4'b0000,
    VOBEI_CL_FP64      = 4'b0001,
    VOBEI_CL_INT       = 4'b0010,
    VOBEI_CL_LOAD      = 4'b0011,
    VOBEI_CL_STORE     = 4'b0100,
    VOBEI_CL_PAIR_LD   = 4'b0101,
    VOBEI_CL_PAIR_ST   = 4'b0110,
    VOBEI_CL_ATOM_LD   = 4'b0111,
    VOBEI_CL_ATOM_ST   = 4'b1000,
    VOBEI_CL_REPL1     = 4'b1001,
    VOBEI_CL_REPLQ     = 4'b1010,
    VOBEI_CL_MULTI_LD  = 4'b1011,
    VOBEI_CL_MULTI_ST  = 4'b1100
  } vobei_class_t;

  // one speculatively executed instruction from the pipeline
  typedef struct packed {
    logic         valid;
    vobei_class_t iclass;
    logic         scalable;   // scalable-vector form
    logic         vector;     // fixed-width vector, else scalar
    logic         fused;      // fused multiply-add / multiply-accumulate
    logic [7:0]   container_bits;
    logic [7:0]   memory_element_bits;
    logic [2:0]   regs;       // registers transferred, 1..4
  } vobei_instr_t;

  typedef logic [7:0] vobei_inc_t;

  typedef struct packed {
    vobei_inc_t fp64_scalable_ops_event;
    vobei_inc_t fp64_fixed_ops_event;
    vobei_inc_t int_scalable_ops_event;
    vobei_inc_t int_fixed_ops_event;
    vobei_inc_t ldst_scalable_ops_event;
    vobei_inc_t ldst_fixed_ops_event;
    vobei_inc_t ld_scalable_ops_event;
    vobei_inc_t ld_fixed_ops_event;
    vobei_inc_t st_scalable_ops_event;
    vobei_inc_t st_fixed_ops_event;
    vobei_inc_t ldst_scalable_bytes_event;
    vobei_inc_t ldst_fixed_bytes_event;
    vobei_inc_t ld_scalable_bytes_event;
    vobei_inc_t ld_fixed_bytes_event;
    vobei_inc_t st_scalable_bytes_event;
    vobei_inc_t st_fixed_bytes_event;
  } vobei_incs_t;
endpackage

//--- tb/vobei_incrementer_properties.sv
// Purpose: port-level properties of the event incrementer
// Assumes: latency of exactly one cycle
// Notes:   attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module vobei_props
  import vobei_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst,
  input wire vobei_instr_t instr,
  input wire vobei_incs_t  incs
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic fp = instr.valid && instr.iclass == VOBEI_CL_FP64;
  wire logic cl_in = instr.valid && instr.iclass == VOBEI_CL_INT;
  wire logic ld_sc = instr.valid && instr.iclass == VOBEI_CL_LOAD
                     && instr.scalable;
  ////////////////////////////////////////////////////////////////////
  AST_IDLE: assert property (!instr.valid |=> incs == '0)
    else $error("increments seen without an instruction");
  AST_FP64_SC: assert property (fp && instr.scalable |=>
    incs.fp64_scalable_ops_event == ($past(instr.fused) ? 8'h04 : 8'h02))
    else $error("scalable fp64 amount wrong");
  AST_FP64_EXCL: assert property (fp && instr.scalable |=>
    incs.fp64_fixed_ops_event == 8'h00)
    else $error("scalable fp64 leaked into fixed event");
  AST_FP64_FX: assert property (fp && !instr.scalable
    && !instr.vector && !instr.fused |=>
    incs.fp64_fixed_ops_event == 8'h01)
    else $error("scalar fp64 amount wrong");
  AST_INT_SC: assert property (cl_in && instr.scalable
    && instr.container_bits == 8'h20 |=>
    incs.int_scalable_ops_event == ($past(instr.fused) ? 8'h08 : 8'h04))
    else $error("scalable int amount wrong");
  AST_LD_SC: assert property (ld_sc |=>
    incs.ld_scalable_ops_event == incs.ldst_scalable_ops_event
    && incs.st_scalable_ops_event == 8'h00)
    else $error("scalable load events disagree");
  AST_PAIR_ST: assert property (instr.valid
    && instr.iclass == VOBEI_CL_PAIR_ST |=>
    incs.st_fixed_ops_event == 8'h02 && incs.ldst_fixed_ops_event == 8'h02)
    else $error("pair store amount wrong");
  AST_REPLQ: assert property (instr.valid
    && instr.iclass == VOBEI_CL_REPLQ |=>
    incs.ldst_fixed_bytes_event == 8'h10 && incs.ld_scalable_ops_event == 0)
    else $error("quadword replicate load amount wrong");
  AST_ATOM_ST: assert property (instr.valid
    && instr.iclass == VOBEI_CL_ATOM_ST |=>
    incs.st_fixed_bytes_event == 8'h00 && incs.st_fixed_ops_event == 8'h01)
    else $error("atomic store amount wrong");
  AST_COV_FMA: cover property (fp && instr.fused);
  AST_COV_MULTI: cover property (instr.valid
    && instr.iclass == VOBEI_CL_MULTI_LD);
  AST_COV_BACK: cover property (instr.valid ##1 instr.valid);
endmodule
bind vobei_incrementer vobei_props i_props (
  .mclk  (mclk),
  .rst   (rst),
  .instr (instr),
  .incs  (incs)
);
`default_nettype wire

//--- tb/vobei_pipe_model.sv
// Purpose: execution pipeline side that presents instructions
// Assumes: bench hands over one instruction per cycle
// Notes:   nothing is issued while the core is in reset
`timescale 1ns/100ps
`default_nettype none
module vobei_pipe_model
  import vobei_pkg::*;
(
  input  wire logic         rst,
  input  wire vobei_instr_t req,
  output var  vobei_instr_t instr
);
  // class, sizes and register count travel together with valid
  assign instr = rst ? '0 : req;
endmodule
`default_nettype wire

//--- tb/vobei_incrementer_tb_top.sv
// Purpose: self-checking bench for the event incrementer
// Assumes: result one cycle after the instruction is taken
// Notes:   expectations are worked out by hand per instruction
`timescale 1ns/100ps
`default_nettype none
module vobei_incrementer_tb_top
  import vobei_pkg::*;
;
  logic         mclk;
  logic         rst;
  vobei_instr_t req;
  vobei_instr_t instr;
  vobei_incs_t  incs;
  int           error_cnt;
  int           comparisons;
  vobei_pipe_model i_pipe (.rst(rst), .req(req), .instr(instr));
  vobei_incrementer i_dut (.mclk(mclk), .rst(rst), .instr(instr),
    .incs(incs));
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////
  function automatic vobei_instr_t mk(vobei_class_t c, logic [2:0] f,
    logic [7:0] cb, logic [7:0] mb, logic [2:0] r);
    mk = {1'b1, c, f, cb, mb, r};
  endfunction
  task automatic chk(vobei_incs_t got, vobei_incs_t exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request stays up so back-to-back calls never rewrite it twice
  task automatic send(vobei_instr_t i, vobei_incs_t e);
    req = i;
    @(posedge mclk);
    #1;
    chk(incs, e);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_fp64();
    send(mk(VOBEI_CL_FP64, 3'b100, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_scalable_ops_event:8'h02});
    send(mk(VOBEI_CL_FP64, 3'b101, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_scalable_ops_event:8'h04});
    send(mk(VOBEI_CL_FP64, 3'b011, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_fixed_ops_event:8'h04});
    send(mk(VOBEI_CL_FP64, 3'b000, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_fixed_ops_event:8'h01});
    send(mk(VOBEI_CL_FP64, 3'b010, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_fixed_ops_event:8'h02});
    $display("test fp64 done");
  endtask
  task automatic t_int();
    send(mk(VOBEI_CL_INT, 3'b101, 8'h20, 8'h20, 3'h1),
      '{default:8'h00, int_scalable_ops_event:8'h08});
    send(mk(VOBEI_CL_INT, 3'b010, 8'h10, 8'h10, 3'h1),
      '{default:8'h00, int_fixed_ops_event:8'h08});
    send(mk(VOBEI_CL_INT, 3'b001, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, int_fixed_ops_event:8'h02});
    $display("test int done");
  endtask
  task automatic t_mem();
    send(mk(VOBEI_CL_LOAD, 3'b100, 8'h20, 8'h20, 3'h2), '{default:8'h00,
      ldst_scalable_ops_event:8'h08, ld_scalable_ops_event:8'h08,
      ldst_scalable_bytes_event:8'h20,
      ld_scalable_bytes_event:8'h20});
    send(mk(VOBEI_CL_STORE, 3'b100, 8'h40, 8'h10, 3'h3), '{default:8'h00,
      ldst_scalable_ops_event:8'h06, st_scalable_ops_event:8'h06,
      ldst_scalable_bytes_event:8'h0C,
      st_scalable_bytes_event:8'h0C});
    send(mk(VOBEI_CL_PAIR_ST, 3'b000, 8'h20, 8'h20, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h02, st_fixed_ops_event:8'h02,
      ldst_fixed_bytes_event:8'h08,
      st_fixed_bytes_event:8'h08});
    send(mk(VOBEI_CL_ATOM_LD, 3'b000, 8'h20, 8'h20, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h02, ldst_fixed_bytes_event:8'h08,
      ld_fixed_ops_event:8'h01, ld_fixed_bytes_event:8'h04,
      st_fixed_bytes_event:8'h04});
    send(mk(VOBEI_CL_ATOM_ST, 3'b000, 8'h40, 8'h40, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h01, ldst_fixed_bytes_event:8'h08,
      st_fixed_ops_event:8'h01});
    send(mk(VOBEI_CL_LOAD, 3'b000, 8'h40, 8'h40, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h01, ld_fixed_ops_event:8'h01,
      ldst_fixed_bytes_event:8'h08,
      ld_fixed_bytes_event:8'h08});
    send(mk(VOBEI_CL_STORE, 3'b000, 8'h10, 8'h10, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h01, st_fixed_ops_event:8'h01,
      ldst_fixed_bytes_event:8'h02,
      st_fixed_bytes_event:8'h02});
    send(mk(VOBEI_CL_PAIR_LD, 3'b000, 8'h40, 8'h40, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h02, ld_fixed_ops_event:8'h02,
      ldst_fixed_bytes_event:8'h10,
      ld_fixed_bytes_event:8'h10});
    $display("test memory done");
  endtask
  task automatic t_repl();
    send(mk(VOBEI_CL_REPLQ, 3'b100, 8'h20, 8'h20, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h04, ld_fixed_ops_event:8'h04,
      ldst_fixed_bytes_event:8'h10,
      ld_fixed_bytes_event:8'h10});
    send(mk(VOBEI_CL_MULTI_LD, 3'b010, 8'h08, 8'h08, 3'h4), '{default:0,
      ldst_fixed_ops_event:8'h40, ld_fixed_ops_event:8'h40,
      ldst_fixed_bytes_event:8'h40,
      ld_fixed_bytes_event:8'h40});
    send(mk(VOBEI_CL_REPL1, 3'b010, 8'h10, 8'h10, 3'h1), '{default:0,
      ldst_fixed_ops_event:8'h01, ld_fixed_ops_event:8'h01,
      ldst_fixed_bytes_event:8'h02,
      ld_fixed_bytes_event:8'h02});
    send(mk(VOBEI_CL_MULTI_ST, 3'b010, 8'h20, 8'h20, 3'h2), '{default:0,
      ldst_fixed_ops_event:8'h08, st_fixed_ops_event:8'h08,
      ldst_fixed_bytes_event:8'h20,
      st_fixed_bytes_event:8'h20});
    $display("test replicate done");
  endtask
  task automatic t_refuse();
    vobei_instr_t i;
    i = mk(VOBEI_CL_FP64, 3'b101, 8'h40, 8'h40, 3'h1);
    i.valid = 1'b0;
    send(i, '0);
    send(mk(VOBEI_CL_NONE, 3'b100, 8'h20, 8'h20, 3'h1), '0);
    $display("test refuse done");
  endtask
  // reset in mid-run clears the increments; first instruction after works
  task automatic t_reset();
    send(mk(VOBEI_CL_FP64, 3'b101, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_scalable_ops_event:8'h04});
    rst = 1'b1;
    @(posedge mclk);
    #1;
    chk(incs, '0);
    rst = 1'b0;
    send(mk(VOBEI_CL_FP64, 3'b101, 8'h40, 8'h40, 3'h1),
      '{default:8'h00, fp64_scalable_ops_event:8'h04});
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    rst = 1'b1;
    req = '0;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    #1;
    t_fp64();
    t_int();
    t_mem();
    t_repl();
    t_refuse();
    t_reset();
    summarize();
  end
  initial
  begin
    repeat (200) @(posedge mclk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
